// ==== verilog/asrc_pkg.sv ====
// Package: constants and types for the static memory host controller
package asrc_pkg;
  localparam int ASRC_ADDR_W = 20;
  localparam int ASRC_DATA_W = 16;
  localparam int ASRC_LANES = 2;
  localparam int ASRC_CLK_MHZ = 20;
  localparam int ASRC_CLK_NS = 50;
  // Power-up wait, in microseconds
  localparam int ASRC_POWER_UP_US = 1000;
  localparam int ASRC_POWER_UP_CYC = (ASRC_POWER_UP_US * 1000 + ASRC_CLK_NS - 1) / ASRC_CLK_NS;
  localparam int ASRC_WAIT_W = 16;
  // Cycles of each access phase
  localparam int ASRC_SETUP_CYC = 1;
  localparam int ASRC_STROBE_CYC = 1;
  localparam int ASRC_RECOVER_CYC = 1;
  localparam int ASRC_PHASE_W = 4;
  localparam logic [ASRC_DATA_W-1:0] ASRC_DATA_RST = 16'h0000;
  localparam logic [ASRC_ADDR_W-1:0] ASRC_ADDR_RST = 20'h00000;
  localparam logic [ASRC_LANES-1:0] ASRC_LANE_OFF = 2'h3;
  typedef enum logic [1:0] {ASRC_OP_IDLE, ASRC_OP_READ, ASRC_OP_WRITE} asrc_op_e;
endpackage

// ==== verilog/asrc_pins_if.sv ====
// Interface: pin-level signals between sequencer and pin driver
`timescale 1ns/1ps
interface asrc_pins_if;
  import asrc_pkg::*;
  logic select;
  logic writeStrobe;
  logic outEnable;
  logic driveData;
  logic [ASRC_LANES-1:0] laneEnN;
  logic [ASRC_DATA_W-1:0] wrData;
  modport seq (output select, output writeStrobe, output outEnable, output driveData,
    output laneEnN, output wrData);
  modport drv (input select, input writeStrobe, input outEnable, input driveData,
    input laneEnN, input wrData);
endinterface

// ==== verilog/asrc_pin_drv.sv ====
// Pin driver: registered memory control pins and data bus enable
`timescale 1ns/1ps
module asrc_pin_drv
  import asrc_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Async reset, high
  input wire logic clkEn, // Clock enable
  asrc_pins_if.drv pins, // From sequencer
  output logic chipSelectActiveLowN, // Select, active low
  output logic chipSelectActiveHigh, // Select, active high
  output logic writeEnableN, // Write strobe
  output logic outputEnableN, // Output enable
  output logic [ASRC_LANES-1:0] laneEnableN, // {high, low} lane enables
  output logic [ASRC_DATA_W-1:0] sharedDataLinesOut, // Data to memory
  output logic sharedDataLinesOe // Drive enable for data lines
);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chipSelectActiveLowN <= 1'b1;
      chipSelectActiveHigh <= 1'b0;
      writeEnableN <= 1'b1;
      outputEnableN <= 1'b1;
      laneEnableN <= ASRC_LANE_OFF;
    end else if (clkEn) begin
      chipSelectActiveLowN <= ~pins.select;
      chipSelectActiveHigh <= pins.select;
      writeEnableN <= ~pins.writeStrobe;
      outputEnableN <= ~pins.outEnable;
      laneEnableN <= pins.laneEnN;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sharedDataLinesOut <= ASRC_DATA_RST;
      sharedDataLinesOe <= 1'b0;
    end else if (clkEn) begin
      sharedDataLinesOut <= pins.wrData;
      sharedDataLinesOe <= pins.driveData;
    end
  end
endmodule

// ==== verilog/asrc_host.sv ====
// Host controller for a 1M x 16 asynchronous static memory
//
// Operation
// - A write needs both selects active and the write strobe held low.
// - A read needs both selects active, output enable low and write strobe high.
// - The host waits at least 1 ms after power-up before any access.
// - Both select pins act as one combined select: the active-low pin low and the active-high pin high.
`timescale 1ns/1ps
module asrc_host
  import asrc_pkg::*;
#(
  parameter int POWER_UP_CYC = ASRC_POWER_UP_CYC
) (
  input wire logic clock, // 20 MHz clock
  input wire logic rst, // Async reset, high
  input wire logic clkEn, // Clock enable, freezes state when low
  input wire logic reqValid, // Access request
  output logic reqReady, // Request taken when both high
  input wire logic reqWrite, // 1 write, 0 read
  input wire logic [ASRC_ADDR_W-1:0] reqAddr, // Word address
  input wire logic [ASRC_LANES-1:0] reqLanes, // Lane mask {high, low}, active high
  input wire logic [ASRC_DATA_W-1:0] reqWrData, // Write data
  output logic rdValid, // Read data pulse
  output logic [ASRC_DATA_W-1:0] rdData, // Read data
  output logic wrDone, // Write finished pulse
  output logic powerUpDone, // Power-up wait elapsed
  output logic [ASRC_ADDR_W-1:0] wordAddress, // Memory address pins
  output logic chipSelectActiveLowN, // Select, active low
  output logic chipSelectActiveHigh, // Select, active high
  output logic writeEnableN, // Write strobe, active low
  output logic outputEnableN, // Output enable, active low
  output logic lowByteLaneEnableN, // Low lane enable
  output logic highByteLaneEnableN, // High lane enable
  input wire logic [ASRC_DATA_W-1:0] sharedDataLinesIn, // Data from bus
  output logic [ASRC_DATA_W-1:0] sharedDataLinesOut, // Data to bus
  output logic sharedDataLinesOe // Host drives data bus when high
);
  typedef enum logic [2:0] {
    ASRC_ST_POWER, ASRC_ST_IDLE, ASRC_ST_SETUP, ASRC_ST_STROBE, ASRC_ST_RECOVER
  } asrc_state_e;

  asrc_pins_if pins();
  asrc_state_e state_r;
  logic [ASRC_WAIT_W-1:0] wait_r;
  logic [ASRC_PHASE_W-1:0] phase_r;
  logic isWrite_r;
  logic [ASRC_LANES-1:0] lanesN_r;
  logic [ASRC_DATA_W-1:0] wrData_r;
  logic [ASRC_LANES-1:0] laneOut;

  function automatic logic [ASRC_DATA_W-1:0] asrc_lane_merge(
    input logic [ASRC_DATA_W-1:0] bus, input logic [ASRC_LANES-1:0] lanesN);
    logic [ASRC_DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < ASRC_LANES; i++) begin
      if (!lanesN[i]) begin
        m[i*8 +: 8] = bus[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Phase counter reload for a phase of cyc cycles
  function automatic logic [ASRC_PHASE_W-1:0] asrc_phase_load(input int cyc);
    return ASRC_PHASE_W'(cyc - 1);
  endfunction

  assign reqReady = (state_r == ASRC_ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Power-up wait
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_r <= '0;
      powerUpDone <= 1'b0;
    end else if (clkEn && !powerUpDone) begin
      if (wait_r == ASRC_WAIT_W'(POWER_UP_CYC - 1)) begin
        powerUpDone <= 1'b1;
      end
      wait_r <= wait_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ASRC_ST_POWER;
      phase_r <= '0;
    end else if (clkEn) begin
      unique case (state_r)
        ASRC_ST_POWER: begin
          if (powerUpDone) begin
            state_r <= ASRC_ST_IDLE;
          end
        end
        ASRC_ST_IDLE: begin
          if (reqValid) begin
            state_r <= ASRC_ST_SETUP;
            phase_r <= asrc_phase_load(ASRC_SETUP_CYC);
          end
        end
        ASRC_ST_SETUP: begin
          if (phase_r == '0) begin
            state_r <= ASRC_ST_STROBE;
            phase_r <= asrc_phase_load(ASRC_STROBE_CYC);
          end else begin
            phase_r <= phase_r - 1'b1;
          end
        end
        ASRC_ST_STROBE: begin
          if (phase_r == '0) begin
            state_r <= ASRC_ST_RECOVER;
            phase_r <= asrc_phase_load(ASRC_RECOVER_CYC);
          end else begin
            phase_r <= phase_r - 1'b1;
          end
        end
        ASRC_ST_RECOVER: begin
          if (phase_r == '0) begin
            state_r <= ASRC_ST_IDLE;
          end else begin
            phase_r <= phase_r - 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      isWrite_r <= 1'b0;
      lanesN_r <= ASRC_LANE_OFF;
      wrData_r <= ASRC_DATA_RST;
      wordAddress <= ASRC_ADDR_RST;
    end else if (clkEn && reqValid && reqReady) begin
      isWrite_r <= reqWrite;
      lanesN_r <= ~reqLanes;
      wrData_r <= reqWrData;
      wordAddress <= reqAddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin levels for the driver; one-cycle lag applied there
  logic active;
  logic pinWe;
  logic pinOe;
  logic pinDrive;
  assign active = (state_r == ASRC_ST_SETUP) || (state_r == ASRC_ST_STROBE);
  assign laneOut = active ? lanesN_r : ASRC_LANE_OFF;
  // Select, strobe, lanes and data drive all drop together at strobe end
  always_comb begin
    pinWe = 1'b0;
    pinOe = 1'b0;
    pinDrive = 1'b0;
    unique case (state_r)
      ASRC_ST_SETUP: begin
        pinOe = !isWrite_r;
        pinDrive = isWrite_r;
      end
      ASRC_ST_STROBE: begin
        pinWe = isWrite_r;
        pinOe = !isWrite_r;
        pinDrive = isWrite_r;
      end
      ASRC_ST_POWER, ASRC_ST_IDLE, ASRC_ST_RECOVER: begin
        pinWe = 1'b0;
      end
    endcase
  end
  assign pins.select = active;
  assign pins.writeStrobe = pinWe;
  assign pins.outEnable = pinOe;
  assign pins.driveData = pinDrive;
  assign pins.laneEnN = laneOut;
  assign pins.wrData = wrData_r;

  asrc_pin_drv u_drv (
    .clock(clock),
    .rst(rst),
    .clkEn(clkEn),
    .pins(pins),
    .chipSelectActiveLowN(chipSelectActiveLowN),
    .chipSelectActiveHigh(chipSelectActiveHigh),
    .writeEnableN(writeEnableN),
    .outputEnableN(outputEnableN),
    .laneEnableN({highByteLaneEnableN, lowByteLaneEnableN}),
    .sharedDataLinesOut(sharedDataLinesOut),
    .sharedDataLinesOe(sharedDataLinesOe)
  );

  ////////////////////////////////////////////////////////////////////////
  // Completion and read capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdValid <= 1'b0;
      wrDone <= 1'b0;
      rdData <= ASRC_DATA_RST;
    end else if (clkEn) begin
      rdValid <= 1'b0;
      wrDone <= 1'b0;
      if (state_r == ASRC_ST_RECOVER && phase_r == '0) begin
        if (isWrite_r) begin
          wrDone <= 1'b1;
        end else begin
          rdValid <= 1'b1;
          rdData <= asrc_lane_merge(sharedDataLinesIn, lanesN_r);
        end
      end
    end
  end
endmodule

// ==== dv/asrc_sram_model.sv ====
// Behavioural model of the 1M x 16 asynchronous static memory
`timescale 1ns/1ps
module asrc_sram_model
  import asrc_pkg::*;
(
  input wire logic [ASRC_ADDR_W-1:0] wordAddress, // Address pins
  input wire logic chipSelectActiveLowN, // Select, active low
  input wire logic chipSelectActiveHigh, // Select, active high
  input wire logic writeEnableN, // Write strobe
  input wire logic outputEnableN, // Output enable
  input wire logic [ASRC_LANES-1:0] laneEnableN, // {high, low} lane enables
  input wire logic [ASRC_DATA_W-1:0] busIn, // Resolved data lines
  output logic [ASRC_DATA_W-1:0] memOut, // Data from the memory
  output logic [ASRC_LANES-1:0] memOe // Per-lane drive enable
);
  logic [ASRC_DATA_W-1:0] mem [0:(1<<ASRC_ADDR_W)-1];
  logic [ASRC_DATA_W-1:0] word;
  logic selected;
  assign selected = !chipSelectActiveLowN && chipSelectActiveHigh;
  // Floats while writing, deselected or disabled
  assign memOe = (selected && !outputEnableN && writeEnableN) ? ~laneEnableN : 2'h0;
  always @(wordAddress or selected or writeEnableN or laneEnableN or busIn) begin
    word = mem[wordAddress];
    if (selected && !writeEnableN) begin
      if (!laneEnableN[0]) word[7:0] = busIn[7:0];
      if (!laneEnableN[1]) word[15:8] = busIn[15:8];
      mem[wordAddress] = word;
    end
    memOut = word;
  end
endmodule

// ==== dv/asrc_host_asserts.sv ====
// Checker of the host controller pin protocol
`timescale 1ns/1ps
module asrc_host_asserts
  import asrc_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic reqValid, // Request
  input wire logic reqReady, // Ready
  input wire logic reqWrite, // Write request
  input wire logic clkEn, // Clock enable
  input wire logic rdValid, // Read pulse
  input wire logic wrDone, // Write pulse
  input wire logic powerUpDone, // Power-up wait over
  input wire logic chipSelectActiveLowN, // Select low
  input wire logic chipSelectActiveHigh, // Select high
  input wire logic writeEnableN, // Write strobe
  input wire logic outputEnableN, // Output enable
  input wire logic sharedDataLinesOe // Host drive enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sel_pair_a: assert property (chipSelectActiveLowN != chipSelectActiveHigh)
    else $error("selects not complementary");
  early_access_a: assert property (!powerUpDone |-> chipSelectActiveLowN)
    else $error("access before power-up wait");
  we_select_a: assert property (!writeEnableN |-> !chipSelectActiveLowN && sharedDataLinesOe)
    else $error("write strobe outside select");
  read_pins_a: assert property (!outputEnableN |-> writeEnableN && !chipSelectActiveLowN)
    else $error("output enable during write");
  no_contend_a: assert property (sharedDataLinesOe |-> outputEnableN)
    else $error("host drives during read");
  we_pulse_a: assert property ($fell(writeEnableN) |=> $rose(writeEnableN) && chipSelectActiveLowN)
    else $error("write strobe not one cycle");
  wr_answer_a: assert property (clkEn && reqValid && reqReady && reqWrite |-> ##4 wrDone)
    else $error("write answer late");
  rd_answer_a: assert property (clkEn && reqValid && reqReady && !reqWrite |-> ##4 rdValid)
    else $error("read answer late");
  one_out_a: assert property (clkEn && reqValid && reqReady |=> !reqReady [*3])
    else $error("second request taken early");
  cover property (rdValid);
  cover property (wrDone);
  cover property ($rose(powerUpDone));
endmodule
bind asrc_host asrc_host_asserts chk (.clock(clock), .rst(rst), .reqValid(reqValid),
  .reqReady(reqReady), .reqWrite(reqWrite), .clkEn(clkEn), .rdValid(rdValid), .wrDone(wrDone),
  .powerUpDone(powerUpDone), .chipSelectActiveLowN(chipSelectActiveLowN),
  .chipSelectActiveHigh(chipSelectActiveHigh), .writeEnableN(writeEnableN),
  .outputEnableN(outputEnableN), .sharedDataLinesOe(sharedDataLinesOe));

// ==== dv/tb.sv ====
// Testbench of the static memory host controller
`timescale 1ns/1ps
module tb;
  import asrc_pkg::*;
  logic clock, rst, clkEn, reqValid, reqReady, reqWrite, rdValid, wrDone, powerUpDone, hostOe;
  logic csLowN, csHigh, weN, oeN, lowN, highN;
  logic [19:0] reqAddr, wordAddress;
  logic [1:0] reqLanes, memOe;
  logic [15:0] reqWrData, rdData, hostOut, memOut, bus, lastBus, lastRd;
  int errors, tests_run;
  asrc_host #(.POWER_UP_CYC(4)) uut (.clock(clock), .rst(rst), .clkEn(clkEn),
    .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqLanes(reqLanes), .reqWrData(reqWrData), .rdValid(rdValid), .rdData(rdData),
    .wrDone(wrDone), .powerUpDone(powerUpDone), .wordAddress(wordAddress),
    .chipSelectActiveLowN(csLowN), .chipSelectActiveHigh(csHigh), .writeEnableN(weN),
    .outputEnableN(oeN), .lowByteLaneEnableN(lowN), .highByteLaneEnableN(highN),
    .sharedDataLinesIn(bus), .sharedDataLinesOut(hostOut), .sharedDataLinesOe(hostOe));
  asrc_sram_model mem (.wordAddress(wordAddress), .chipSelectActiveLowN(csLowN),
    .chipSelectActiveHigh(csHigh), .writeEnableN(weN), .outputEnableN(oeN),
    .laneEnableN({highN, lowN}), .busIn(bus), .memOut(memOut), .memOe(memOe));
  // Undriven lanes show the inverse of the last level
  always @* begin
    bus = ~lastBus;
    if (memOe[0]) bus[7:0] = memOut[7:0];
    if (memOe[1]) bus[15:8] = memOut[15:8];
    if (hostOe) bus = hostOut;
  end
  always @(posedge clock) lastBus <= bus;
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [19:0] a, input logic [1:0] ln,
    input logic [15:0] d);
    int n;
    n = 0;
    reqValid = 1'b1; reqWrite = wr; reqAddr = a; reqLanes = ln; reqWrData = d;
    while (reqReady !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    reqValid = 1'b0;
    n = 1;
    while (rdValid !== 1'b1 && wrDone !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    check(n, 4);
    check(wrDone, wr);
    lastRd = rdData;
  endtask
  task automatic t_power();
    check({powerUpDone, reqReady, csLowN, csHigh}, 4'h2);
    repeat (6) @(negedge clock);
    check({powerUpDone, reqReady}, 2'h3);
    $display("test power done");
  endtask
  task automatic t_full();
    access(1'b1, 20'hfffff, 2'h3, 16'ha5c3);
    access(1'b1, 20'h00000, 2'h3, 16'h5a3c);
    access(1'b0, 20'hfffff, 2'h3, 16'h0000);
    check(lastRd, 16'ha5c3);
    access(1'b0, 20'h00000, 2'h3, 16'h0000);
    check(lastRd, 16'h5a3c);
    $display("test full done");
  endtask
  task automatic t_lanes();
    logic [15:0] exp;
    for (int l = 0; l < 4; l++) begin
      exp = {l[1] ? 8'h3c : 8'hff, l[0] ? 8'hc3 : 8'hff};
      access(1'b1, 20'h00010 + 20'(l), 2'h3, 16'hffff);
      access(1'b1, 20'h00010 + 20'(l), 2'(l), 16'h3cc3);
      access(1'b0, 20'h00010 + 20'(l), 2'h3, 16'h0000);
      check(lastRd, exp);
      access(1'b0, 20'h00010 + 20'(l), 2'(l), 16'h0000);
      check(lastRd, exp & {{8{l[1]}}, {8{l[0]}}});
    end
    check({csLowN, csHigh, hostOe, weN, oeN}, 5'h13);
    $display("test lanes done");
  endtask
  task automatic t_freeze();
    @(negedge clock);
    clkEn = 1'b0;
    reqValid = 1'b1;
    reqWrite = 1'b0;
    reqAddr = 20'hfffff;
    reqLanes = 2'h3;
    repeat (3) @(negedge clock);
    check({reqReady, csLowN, rdValid, powerUpDone}, 4'hd);
    clkEn = 1'b1;
    access(1'b0, 20'hfffff, 2'h3, 16'h0000);
    check(lastRd, 16'ha5c3);
    $display("test freeze done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    errors = 0; tests_run = 0; lastBus = 16'h0000; lastRd = 16'h0000;
    rst = 1'b1; reqValid = 1'b0; reqWrite = 1'b0; reqAddr = 20'h00000;
    reqLanes = 2'h0; reqWrData = 16'h0000;
    clkEn = 1'b1;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    t_power();
    t_full();
    t_lanes();
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    t_power();
    t_freeze();
    close_out();
  end
  initial begin
    #(2000 * 50);
    errors++;
    close_out();
  end
endmodule
